// >>> core/tpc_defines.svh
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH
// Register byte addresses
`define TPC_A_TSC 8'h51
`define TPC_A_CNTH 8'h52
`define TPC_A_CNTL 8'h53
`define TPC_A_MODH 8'h54
`define TPC_A_MODL 8'h55
`define TPC_A_SC0 8'h56
`define TPC_CH_STRIDE 8'h03
`define TPC_OFS_VH 8'h01
`define TPC_OFS_VL 8'h02
// Main control and status bits
`define TPC_B_FLAG 7
`define TPC_B_IE 6
`define TPC_B_STOP 5
`define TPC_B_TRST 4
`define TPC_PS_HI 2
`define TPC_PS_LO 0
// Channel control and status bits
`define TPC_B_MSB 5
`define TPC_B_MSA 4
`define TPC_B_ELSB 3
`define TPC_B_ELSA 2
`define TPC_B_TOV 1
`define TPC_B_MAX 0
// Reset and fixed values
`define TPC_MOD_RST 16'hFFFF
`define TPC_ZERO16 16'h0000
`define TPC_ONE16 16'h0001
`define TPC_ZERO8 8'h00
`define TPC_ONE8 8'h01
`define TPC_ONE7 7'h01
`define TPC_ZERO7 7'h00
`endif

// >>> core/tpc_pkg.sv
`default_nettype none
package tpc_pkg;
  typedef struct packed {
    logic [7:0] rdata;
    logic irq;
    logic wrap_irq_enable;
    logic counter_halt_bit;
    logic [2:0] clock_divider_select;
    logic wrap_flag;
    logic wrap_arm;
    logic mod_lock;
    logic [15:0] cnt;
    logic [6:0] presc;
    logic [15:0] modv;
    logic [1:0] event_flag;
    logic [1:0] flag_arm;
    logic [1:0] irq_enable;
    logic link_pair_select;
    logic [1:0] mode_lower;
    logic [1:0] edge_upper;
    logic [1:0] edge_lower;
    logic [1:0] toggle_on_wrap;
    logic [1:0] full_duty_bit;
    logic [1:0][15:0] val;
    logic [1:0] pin_q;
    logic [1:0] pin_o;
    logic [1:0] oe;
    logic act;
    logic pend;
  } tpc_state_type;
endpackage
`default_nettype wire

// >>> core/tpc_timer.sv
// Implementation choice: strobed register access.
`include "tpc_defines.svh"
`default_nettype none
module tpc_timer (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic wait_i,
  input wire logic stop_i,
  input wire logic brk_i,
  input wire logic break_clear_enable_i,
  input wire logic channel_zero_pin_i,
  input wire logic channel_one_pin_i,
  output logic [7:0] rdata_o,
  output logic irq_o,
  output logic channel_zero_pin_o,
  output logic channel_zero_pin_oe_o,
  output logic channel_one_pin_o,
  output logic channel_one_pin_oe_o
);
  tpc_pkg::tpc_state_type st_reg;
  tpc_pkg::tpc_state_type st_next;
  logic wr, rd, prot, run, tick, wrap;
  logic [6:0] mask;
  logic [1:0] pin_in, ocm, icm, cmp, cap;
  logic [7:0] base, rv;
  logic [15:0] cval;
  logic p;

  assign pin_in = {channel_one_pin_i, channel_zero_pin_i};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    st_next.rdata = `TPC_ZERO8;
    ocm = 2'b00;
    icm = 2'b00;
    cmp = 2'b00;
    cap = 2'b00;
    base = `TPC_ZERO8;
    rv = `TPC_ZERO8;
    cval = `TPC_ZERO16;
    p = 1'b0;
    // Bus is cut off while waiting
    wr = wr_i && !wait_i;
    rd = rd_i && !wait_i;
    prot = brk_i && !break_clear_enable_i;
    run = !st_reg.counter_halt_bit && !brk_i && !stop_i;
    // Code 111 is not guarded: it divides by 128, software must avoid it
    mask = 7'((`TPC_ONE8 << st_reg.clock_divider_select) - `TPC_ONE8);
    tick = run && ((st_reg.presc & mask) == mask);
    wrap = tick && (st_reg.cnt == st_reg.modv);
    if (run) begin
      st_next.presc = st_reg.presc + `TPC_ONE7;
    end
    if (tick) begin
      st_next.cnt = wrap ? `TPC_ZERO16 : st_reg.cnt + `TPC_ONE16;
    end

    // Main register write
    if (wr && addr_i == `TPC_A_TSC) begin
      st_next.wrap_irq_enable = wdata_i[`TPC_B_IE];
      st_next.counter_halt_bit = wdata_i[`TPC_B_STOP];
      st_next.clock_divider_select = wdata_i[`TPC_PS_HI:`TPC_PS_LO];
      if (!wdata_i[`TPC_B_FLAG] && st_reg.wrap_arm && !prot) begin
        st_next.wrap_flag = 1'b0;
        st_next.wrap_arm = 1'b0;
      end
      if (wdata_i[`TPC_B_TRST]) begin
        st_next.cnt = `TPC_ZERO16;
        st_next.presc = `TPC_ZERO7;
      end
    end
    if (wr && addr_i == `TPC_A_MODH) begin
      st_next.modv[15:8] = wdata_i;
      st_next.mod_lock = 1'b1;
    end
    if (wr && addr_i == `TPC_A_MODL) begin
      st_next.modv[7:0] = wdata_i;
      st_next.mod_lock = 1'b0;
    end

    // Main register read
    if (rd && addr_i == `TPC_A_TSC) begin
      rv[`TPC_B_FLAG] = st_reg.wrap_flag;
      rv[`TPC_B_IE] = st_reg.wrap_irq_enable;
      rv[`TPC_B_STOP] = st_reg.counter_halt_bit;
      rv[`TPC_PS_HI:`TPC_PS_LO] = st_reg.clock_divider_select;
      st_next.rdata = rv;
      if (st_reg.wrap_flag && !prot) begin
        st_next.wrap_arm = 1'b1;
      end
    end
    if (rd && addr_i == `TPC_A_CNTH) begin
      st_next.rdata = st_reg.cnt[15:8];
    end
    if (rd && addr_i == `TPC_A_CNTL) begin
      st_next.rdata = st_reg.cnt[7:0];
    end
    if (rd && addr_i == `TPC_A_MODH) begin
      st_next.rdata = st_reg.modv[15:8];
    end
    if (rd && addr_i == `TPC_A_MODL) begin
      st_next.rdata = st_reg.modv[7:0];
    end

    // Wrap event; a set in the clear cycle still wins
    if (wrap && !st_reg.mod_lock) begin
      st_next.wrap_flag = 1'b1;
      st_next.wrap_arm = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    for (int i = 0; i < 2; i++) begin
      base = 8'(`TPC_A_SC0 + 8'(i) * `TPC_CH_STRIDE);
      if (i == 0) begin
        // Link bit alone already selects compare mode
        ocm[i] = st_reg.link_pair_select || st_reg.mode_lower[0];
      end else begin
        ocm[i] = st_reg.mode_lower[1] && !st_reg.link_pair_select;
      end
      icm[i] = !(i == 0 ? st_reg.link_pair_select : st_reg.link_pair_select)
               && !st_reg.mode_lower[i]
               && (st_reg.edge_upper[i] || st_reg.edge_lower[i]);
      if (i == 0) begin
        icm[i] = !st_reg.link_pair_select && !st_reg.mode_lower[0]
                 && (st_reg.edge_upper[0] || st_reg.edge_lower[0]);
      end
      // Linked pair compares against the active channel, which takes the last written one only at wrap
      cval = (i == 0 && st_reg.link_pair_select) ? st_reg.val[st_reg.act]
                                                 : st_reg.val[i];
      cmp[i] = tick && ocm[i] && (st_reg.cnt == cval);
      cap[i] = icm[i] && run
               && ((st_reg.edge_lower[i] && pin_in[i] && !st_reg.pin_q[i])
               || (st_reg.edge_upper[i] && !pin_in[i] && st_reg.pin_q[i]));
      st_next.pin_q[i] = pin_in[i];

      // Channel register writes
      if (wr && addr_i == base) begin
        st_next.irq_enable[i] = wdata_i[`TPC_B_IE];
        if (i == 0) begin
          st_next.link_pair_select = wdata_i[`TPC_B_MSB];
        end
        st_next.mode_lower[i] = wdata_i[`TPC_B_MSA];
        st_next.edge_upper[i] = wdata_i[`TPC_B_ELSB];
        st_next.edge_lower[i] = wdata_i[`TPC_B_ELSA];
        st_next.toggle_on_wrap[i] = wdata_i[`TPC_B_TOV];
        st_next.full_duty_bit[i] = wdata_i[`TPC_B_MAX];
        if (!wdata_i[`TPC_B_FLAG] && st_reg.flag_arm[i] && !prot) begin
          st_next.event_flag[i] = 1'b0;
          st_next.flag_arm[i] = 1'b0;
        end
      end
      if (wr && addr_i == 8'(base + `TPC_OFS_VH)) begin
        st_next.val[i][15:8] = wdata_i;
        st_next.pend = 1'(i);
      end
      if (wr && addr_i == 8'(base + `TPC_OFS_VL)) begin
        st_next.val[i][7:0] = wdata_i;
        st_next.pend = 1'(i);
      end

      // Channel register reads
      if (rd && addr_i == base) begin
        rv = `TPC_ZERO8;
        rv[`TPC_B_FLAG] = st_reg.event_flag[i];
        rv[`TPC_B_IE] = st_reg.irq_enable[i];
        rv[`TPC_B_MSB] = (i == 0) && st_reg.link_pair_select;
        rv[`TPC_B_MSA] = st_reg.mode_lower[i];
        rv[`TPC_B_ELSB] = st_reg.edge_upper[i];
        rv[`TPC_B_ELSA] = st_reg.edge_lower[i];
        rv[`TPC_B_TOV] = st_reg.toggle_on_wrap[i];
        rv[`TPC_B_MAX] = st_reg.full_duty_bit[i];
        st_next.rdata = rv;
        if (st_reg.event_flag[i] && !prot) begin
          st_next.flag_arm[i] = 1'b1;
        end
      end
      if (rd && addr_i == 8'(base + `TPC_OFS_VH)) begin
        st_next.rdata = st_reg.val[i][15:8];
      end
      if (rd && addr_i == 8'(base + `TPC_OFS_VL)) begin
        st_next.rdata = st_reg.val[i][7:0];
      end

      // Events set after the clears so that a set wins
      if (cmp[i] || cap[i]) begin
        st_next.event_flag[i] = 1'b1;
        st_next.flag_arm[i] = 1'b0;
      end
      if (cap[i]) begin
        st_next.val[i] = st_reg.cnt;
      end

      // Pin level: compare action, then wrap toggle, full duty last
      p = st_reg.pin_o[i];
      if (cmp[i]) begin
        case ({st_reg.edge_upper[i], st_reg.edge_lower[i]})
          2'b01: p = !p;
          2'b10: p = 1'b0;
          2'b11: p = 1'b1;
          default: p = st_reg.pin_o[i];
        endcase
      end
      if (wrap && st_reg.toggle_on_wrap[i]) begin
        p = !p;
      end
      if (st_reg.full_duty_bit[i] && st_reg.toggle_on_wrap[i]) begin
        p = !st_reg.edge_lower[i];
      end
      if (ocm[i]) begin
        st_next.pin_o[i] = p;
      end
      // Edge pair 00 leaves the pin to the general port
      st_next.oe[i] = ocm[i]
                      && (st_reg.edge_upper[i] || st_reg.edge_lower[i]);
    end

    // Buffered pair swaps its active channel only at wrap
    if (!st_reg.link_pair_select) begin
      st_next.act = 1'b0;
    end else if (wrap) begin
      st_next.act = st_reg.pend;
    end

    st_next.irq = (st_next.wrap_flag && st_next.wrap_irq_enable)
                  || (st_next.event_flag[0] && st_next.irq_enable[0])
                  || (st_next.event_flag[1] && st_next.irq_enable[1]
                      && !st_next.link_pair_select);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
      st_reg.counter_halt_bit <= 1'b1;
      st_reg.modv <= `TPC_MOD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign channel_zero_pin_o = st_reg.pin_o[0];
  assign channel_zero_pin_oe_o = st_reg.oe[0];
  assign channel_one_pin_o = st_reg.pin_o[1];
  assign channel_one_pin_oe_o = st_reg.oe[1];

  ////////////////////////////////////////////////////////////////////////
  property p_halt_freeze;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_reg.counter_halt_bit && !(wr && addr_i == `TPC_A_TSC))
    |=> $stable(st_reg.cnt);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze)
    else $error("counter moved while halted");

  property p_clear;
    @(posedge mclk_i) disable iff (!rstn_i)
    (wr && addr_i == `TPC_A_TSC && wdata_i[`TPC_B_TRST])
    |=> (st_reg.cnt == `TPC_ZERO16) && (st_reg.presc == `TPC_ZERO7);
  endproperty
  a_clear: assert property (p_clear)
    else $error("counter clear did not zero counter");

  property p_wrap;
    @(posedge mclk_i) disable iff (!rstn_i)
    (wrap && !st_reg.mod_lock) |=> st_reg.wrap_flag;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap flag not set at period limit");

  property p_restart;
    @(posedge mclk_i) disable iff (!rstn_i)
    (wrap && !(wr && addr_i == `TPC_A_TSC)) |=> st_reg.cnt == `TPC_ZERO16;
  endproperty
  a_restart: assert property (p_restart)
    else $error("counter did not restart after limit");

  property p_lock;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_reg.mod_lock && !st_reg.wrap_flag) |=> !st_reg.wrap_flag;
  endproperty
  a_lock: assert property (p_lock)
    else $error("wrap flag set while limit half written");

  property p_one_write;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_reg.wrap_flag && wr && addr_i == `TPC_A_TSC
     && wdata_i[`TPC_B_FLAG]) |=> st_reg.wrap_flag;
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("writing one cleared the wrap flag");

  // Without a prior armed read no write may clear the flag
  property p_unarmed_keep;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_reg.wrap_flag && !st_reg.wrap_arm) |=> st_reg.wrap_flag;
  endproperty
  a_unarmed_keep: assert property (p_unarmed_keep)
    else $error("wrap flag cleared without armed read");

  property p_wrap_irq;
    @(posedge mclk_i) disable iff (!rstn_i)
    ($rose(st_reg.wrap_flag) && st_reg.wrap_irq_enable) |-> irq_o;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq)
    else $error("enabled wrap gave no interrupt");

  property p_chan_irq;
    @(posedge mclk_i) disable iff (!rstn_i)
    (!st_reg.wrap_flag && !st_reg.event_flag[1] && !st_reg.irq_enable[0])
    |-> !irq_o;
  endproperty
  a_chan_irq: assert property (p_chan_irq)
    else $error("interrupt without enabled source");

  property p_freeze;
    @(posedge mclk_i) disable iff (!rstn_i)
    (stop_i && !wr) |=> $stable(st_reg.cnt) && $stable(st_reg.event_flag);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("timer moved in stop");

  property p_break_hold;
    @(posedge mclk_i) disable iff (!rstn_i)
    (brk_i && !(wr && addr_i == `TPC_A_TSC)) |=> $stable(st_reg.cnt);
  endproperty
  a_break_hold: assert property (p_break_hold)
    else $error("counter moved during break");

  // Halt clears run, which gates both tick and capture, so neither capture nor compare can flag
  property p_halt_events;
    @(posedge mclk_i) disable iff (!rstn_i)
    st_reg.counter_halt_bit
    |=> !$rose(st_reg.event_flag[0]) && !$rose(st_reg.event_flag[1]);
  endproperty
  a_halt_events: assert property (p_halt_events)
    else $error("channel event while halted");

  property p_full;
    @(posedge mclk_i) disable iff (!rstn_i)
    (st_reg.full_duty_bit[0] && st_reg.toggle_on_wrap[0] && ocm[0])
    |=> channel_zero_pin_o == !$past(st_reg.edge_lower[0]);
  endproperty
  a_full: assert property (p_full)
    else $error("full duty output not constant");

  property p_wait_bus;
    @(posedge mclk_i) disable iff (!rstn_i)
    (wait_i && rd_i) |=> rdata_o == `TPC_ZERO8;
  endproperty
  a_wait_bus: assert property (p_wait_bus)
    else $error("register read during wait");
endmodule
`default_nettype wire

// >>> bench/tpc_pin_model.sv
`default_nettype none
module tpc_pin_model (
  input wire logic mclk_i,
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  input wire logic level_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared pin: the timer drives it when enabled, else outside circuit
  always_ff @(posedge mclk_i) begin
    pin_o <= pin_oe_i ? pin_drv_i : level_i;
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic wait_i = 1'b0;
  logic stop_i = 1'b0;
  logic brk_i = 1'b0;
  logic bce_i = 1'b0;
  logic lvl0 = 1'b0;
  logic lvl1 = 1'b0;
  logic p0_in, p1_in;
  logic [7:0] rdata_o;
  logic irq_o, p0_o, p0_oe, p1_o, p1_oe;
  logic [7:0] rv, rw;
  logic [7:0] ctl [4] = '{8'h1a, 8'h1e, 8'h18, 8'h1b};
  int hi [4] = '{10, 10, 0, 20};
  int n;
  int err_count = 0;
  int checks = 0;
  tpc_timer tpc_timer_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .wait_i(wait_i),
    .stop_i(stop_i), .brk_i(brk_i), .break_clear_enable_i(bce_i),
    .channel_zero_pin_i(p0_in), .channel_one_pin_i(p1_in),
    .rdata_o(rdata_o), .irq_o(irq_o), .channel_zero_pin_o(p0_o),
    .channel_zero_pin_oe_o(p0_oe), .channel_one_pin_o(p1_o),
    .channel_one_pin_oe_o(p1_oe)
  );
  tpc_pin_model pin0_inst (.mclk_i(mclk_i), .pin_oe_i(p0_oe),
    .pin_drv_i(p0_o), .level_i(lvl0), .pin_o(p0_in));
  tpc_pin_model pin1_inst (.mclk_i(mclk_i), .pin_oe_i(p1_oe),
    .pin_drv_i(p1_o), .level_i(lvl1), .pin_o(p1_in));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdc(input string what, input logic [7:0] a,
                     input logic [7:0] exp);
    rd(a, rv);
    check(what, rv, exp);
  endtask
  // Counts high samples of the channel zero pin over two periods
  task automatic sample_duty();
    n = 0;
    repeat (20) begin
      @(posedge mclk_i);
      #1 n += int'(p0_o === 1'b1);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    err_count++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rdc("main reset", 8'h51, 8'h20);
    rdc("limit high reset", 8'h54, 8'hff);
    rdc("unmapped", 8'h70, 8'h00);
    // Set-up order: halt and clear, limit, width, mode, run
    wr(8'h51, 8'h30);
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h09);
    wr(8'h57, 8'h00);
    wr(8'h58, 8'h04);
    for (int i = 0; i < 4; i++) begin
      wr(8'h56, ctl[i]);
      wr(8'h51, 8'h00);
      repeat (30) @(posedge mclk_i);
      sample_duty();
      check("duty", 8'(n), 8'(hi[i]));
      check("oe0", {7'h0, p0_oe}, 8'h01);
    end
    brk_i <= 1'b1;
    rd(8'h53, rw);
    repeat (5) @(posedge mclk_i);
    rdc("break count", 8'h53, rw);
    brk_i <= 1'b0;
    stop_i <= 1'b1;
    rd(8'h53, rw);
    repeat (5) @(posedge mclk_i);
    rdc("stop count", 8'h53, rw);
    stop_i <= 1'b0;
    wait_i <= 1'b1;
    rdc("wait read", 8'h51, 8'h00);
    wait_i <= 1'b0;
    wr(8'h51, 8'h20);
    rd(8'h53, rw);
    repeat (5) @(posedge mclk_i);
    rdc("halt count", 8'h53, rw);
    check("irq off", {7'h0, irq_o}, 8'h00);
    wr(8'h51, 8'he0);
    repeat (2) @(posedge mclk_i);
    check("irq on", {7'h0, irq_o}, 8'h01);
    rdc("wrap arm", 8'h51, 8'he0);
    // Stay halted so no new wrap or compare can undo the clears below
    wr(8'h51, 8'h60);
    rdc("wrap clear", 8'h51, 8'h60);
    repeat (2) @(posedge mclk_i);
    check("irq gone", {7'h0, irq_o}, 8'h00);
    rdc("ch0 arm", 8'h56, 8'h9b);
    brk_i <= 1'b1;
    wr(8'h56, 8'h1b);
    rdc("break keeps flag", 8'h56, 8'h9b);
    brk_i <= 1'b0;
    wr(8'h56, 8'h1b);
    rdc("clear after break", 8'h56, 8'h1b);
    wr(8'h51, 8'h30);
    rdc("count cleared", 8'h53, 8'h00);
    rdc("clear bit reads 0", 8'h51, 8'h20);
    wr(8'h59, 8'h04);
    lvl1 <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rdc("halted capture", 8'h59, 8'h04);
    lvl1 <= 1'b0;
    wr(8'h51, 8'h00);
    repeat (4) @(posedge mclk_i);
    lvl1 <= 1'b1;
    repeat (4) @(posedge mclk_i);
    rdc("capture flag", 8'h59, 8'h84);
    check("oe1", {7'h0, p1_oe}, 8'h00);
    check("p1 level", {7'h0, p1_o}, 8'h00);
    wr(8'h51, 8'h30);
    wr(8'h51, 8'h02);
    repeat (20) @(posedge mclk_i);
    rdc("divide by 4", 8'h53, 8'h05);
    wr(8'h51, 8'h20);
    rdc("ch0 rearm", 8'h56, 8'h9b);
    bce_i <= 1'b1;
    brk_i <= 1'b1;
    wr(8'h56, 8'h1b);
    brk_i <= 1'b0;
    bce_i <= 1'b0;
    rdc("break clear enabled", 8'h56, 8'h1b);
    wr(8'h51, 8'h30);
    wr(8'h5a, 8'h00);
    wr(8'h5b, 8'h08);
    wr(8'h56, 8'h3a);
    wr(8'h51, 8'h00);
    repeat (30) @(posedge mclk_i);
    sample_duty();
    check("linked duty", 8'(n), 8'h12);
    rdc("link mode", 8'h56, 8'hba);
    finish_test();
  end
endmodule
`default_nettype wire
